/* shared/avc_consts.vh */
// constants for the audio volume and mute chain
`ifndef AVC_CONSTS_VH
`define AVC_CONSTS_VH
`define AVC_ADDR_LEFT_GAIN 8'h09
`define AVC_ADDR_RIGHT_GAIN 8'h0c
`define AVC_GAIN_RESET 8'hf1
`define AVC_ZC_BASE 11'h080
`define AVC_DEEMPH_OFF 2'h1
`define AVC_TYPE_SINGLE 2'h0
`define AVC_TYPE_BAD 2'h3
`define AVC_RAMP_MUTE 11'h425
`define AVC_VOL_MUTE_CODE 8'hff
`define AVC_FAST_FRAC 8'h25
`define AVC_FAST_WHOLE 11'h004
`define AVC_FS_DIV 568
`endif

/* design/avc_ramp.v */
// soft volume ramp for one output channel
`timescale 1ns/100ps
`default_nettype none
`include "avc_consts.vh"
module avc_ramp (
   input wire clock, // system clock
   input wire rst_n, // synchronised reset, active low
   input wire tick, // one pulse per sample period
   input wire fast, // short transition time select
   input wire [10:0] target, // wanted attenuation level
   output reg [10:0] level_r // current attenuation level
);
   reg [7:0] frac_r;
   wire [8:0] frac_sum;
   wire [10:0] step;
   wire [11:0] up;
   wire [10:0] gap_up;
   wire [10:0] gap_dn;

   // fast: 1061 levels per 256 periods, whole part 4, fraction 37/256
   assign frac_sum = {1'b0, frac_r} + {1'b0, `AVC_FAST_FRAC};
   assign step = fast ? (`AVC_FAST_WHOLE + {10'h000, frac_sum[8]}) : 11'h001;
   assign up = {1'b0, level_r} + {1'b0, step};
   assign gap_up = target - level_r;
   assign gap_dn = level_r - target;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level_r <= 11'h000;
         frac_r <= 8'h00;
      end else if (tick) begin
         if (fast) begin
            frac_r <= frac_sum[7:0];
         end
         // moves from wherever it stands toward a changed target
         if (level_r < target) begin
            level_r <= (gap_up <= step) ? target : up[10:0];
         end else if (level_r > target) begin
            level_r <= (gap_dn <= step) ? target : level_r - step;
         end
      end
   end
endmodule
`default_nettype wire

/* design/avc_chain.v */
// gain chain: level-stage manual gain, de-emphasis, output volume, soft mute
`timescale 1ns/100ps
`default_nettype none
`include "avc_consts.vh"
module avc_chain #(
   parameter FS_DIV = `AVC_FS_DIV, // clock cycles per sample period
   parameter SW = 24 // sample width
) (
   input wire clock, // 25 MHz system clock
   input wire reset_n, // asynchronous reset, active low
   input wire wr_en, // register write strobe
   input wire [7:0] wr_addr, // register write address
   input wire [7:0] wr_data, // register write data
   input wire rd_en, // register read strobe
   input wire [7:0] rd_addr, // register read address
   output reg [7:0] rd_data, // register read data, one cycle after rd_en
   input wire level_ctl_en, // level control enable
   input wire converter_power, // converter power
   input wire zero_cross_disable, // 1: gain changes apply at once
   input wire [1:0] zc_timeout_sel, // zero-crossing timeout select
   input wire [1:0] deemph_sel, // de-emphasis mode select
   input wire [7:0] left_out_volume, // left output volume code
   input wire [7:0] right_out_volume, // right output volume code
   input wire volume_link, // left code sets both channels
   input wire ramp_time_sel, // 1: short transition time
   input wire soft_silence, // soft mute request
   input wire hp_differential_sel, // differential headphone select
   input wire hp_pseudo_sel, // pseudo cap-less headphone select
   input wire [SW-1:0] sample_left, // left sample, same clock
   input wire [SW-1:0] sample_right, // right sample, same clock
   output reg [7:0] left_level_gain_r, // applied left level-stage gain
   output reg [7:0] right_level_gain_r, // applied right level-stage gain
   output reg [1:0] deemph_mode_r, // de-emphasis mode in effect
   output reg [1:0] hp_out_type_r, // headphone output type in effect
   output wire [10:0] left_vol_level, // left attenuation level, 0 = +12 dB
   output wire [10:0] right_vol_level, // right attenuation level
   output wire fs_tick // sample-rate pulse
);
   reg rst_meta_r;
   reg rst_sync_r;
   reg [15:0] div_r;
   reg tick_r;
   reg [7:0] left_level_gain_code;
   reg [7:0] right_level_gain_code;
   reg [10:0] zc_cnt_left_r;
   reg [10:0] zc_cnt_right_r;
   reg sign_left_r;
   reg sign_right_r;
   reg alc_run_r;
   wire alc_run;
   wire [10:0] zc_limit;
   wire zc_left;
   wire zc_right;
   wire to_left;
   wire to_right;
   wire wr_left;
   wire wr_right;
   wire [7:0] vol_code_left;
   wire [7:0] vol_code_right;
   wire [10:0] tgt_left;
   wire [10:0] tgt_right;

   // reset release through two flops
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // sample-rate divider
   always @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         div_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (div_r == FS_DIV[15:0] - 16'h0001) begin
         div_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end
   assign fs_tick = tick_r;

   assign alc_run = level_ctl_en & converter_power;
   assign zc_limit = `AVC_ZC_BASE << zc_timeout_sel;
   // changed-value writes only, and none while level control runs
   assign wr_left = wr_en & (wr_addr == `AVC_ADDR_LEFT_GAIN) & ~alc_run
      & (wr_data != left_level_gain_code);
   assign wr_right = wr_en & (wr_addr == `AVC_ADDR_RIGHT_GAIN) & ~alc_run
      & (wr_data != right_level_gain_code);

   // sign change between consecutive samples
   assign zc_left = tick_r & (sample_left[SW-1] != sign_left_r);
   assign zc_right = tick_r & (sample_right[SW-1] != sign_right_r);
   assign to_left = tick_r & (zc_cnt_left_r >= zc_limit - 11'h001);
   assign to_right = tick_r & (zc_cnt_right_r >= zc_limit - 11'h001);

   // software-visible gain registers
   always @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         left_level_gain_code <= `AVC_GAIN_RESET;
         right_level_gain_code <= `AVC_GAIN_RESET;
         rd_data <= 8'h00;
      end else begin
         if (wr_left) begin
            left_level_gain_code <= wr_data;
         end
         if (wr_right) begin
            right_level_gain_code <= wr_data;
         end
         if (rd_en) begin
            case (rd_addr)
               `AVC_ADDR_LEFT_GAIN: rd_data <= left_level_gain_code;
               `AVC_ADDR_RIGHT_GAIN: rd_data <= right_level_gain_code;
               default: rd_data <= 8'h00;
            endcase
         end
      end
   end

   // manual level stage with zero-crossing timing
   always @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         left_level_gain_r <= `AVC_GAIN_RESET;
         right_level_gain_r <= `AVC_GAIN_RESET;
         zc_cnt_left_r <= 11'h000;
         zc_cnt_right_r <= 11'h000;
         sign_left_r <= 1'b0;
         sign_right_r <= 1'b0;
         alc_run_r <= 1'b0;
      end else begin
         alc_run_r <= alc_run;
         if (tick_r) begin
            sign_left_r <= sample_left[SW-1];
            sign_right_r <= sample_right[SW-1];
         end
         if (alc_run & ~alc_run_r) begin
            left_level_gain_r <= left_level_gain_code;
            right_level_gain_r <= left_level_gain_code;
         end
         // gain held by the level-control side while it runs
         if (alc_run | wr_left | left_level_gain_r == left_level_gain_code) begin
            zc_cnt_left_r <= 11'h000;
         end else if (zero_cross_disable | zc_left | to_left) begin
            left_level_gain_r <= left_level_gain_code;
            zc_cnt_left_r <= 11'h000;
         end else if (tick_r) begin
            zc_cnt_left_r <= zc_cnt_left_r + 11'h001;
         end
         if (alc_run | wr_right | right_level_gain_r == right_level_gain_code) begin
            zc_cnt_right_r <= 11'h000;
         end else if (zero_cross_disable | zc_right | to_right) begin
            right_level_gain_r <= right_level_gain_code;
            zc_cnt_right_r <= 11'h000;
         end else if (tick_r) begin
            zc_cnt_right_r <= zc_cnt_right_r + 11'h001;
         end
      end
   end

   // de-emphasis and output type
   always @(posedge clock or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         deemph_mode_r <= `AVC_DEEMPH_OFF;
         hp_out_type_r <= `AVC_TYPE_SINGLE;
      end else begin
         deemph_mode_r <= deemph_sel;
         // the unavailable combination keeps the previous type
         if ({hp_differential_sel, hp_pseudo_sel} != `AVC_TYPE_BAD) begin
            hp_out_type_r <= {hp_differential_sel, hp_pseudo_sel};
         end
      end
   end

   // output volume targets
   assign vol_code_left = left_out_volume;
   assign vol_code_right = volume_link ? left_out_volume : right_out_volume;
   assign tgt_left = avc_lvl(vol_code_left, soft_silence);
   assign tgt_right = avc_lvl(vol_code_right, soft_silence);

   // code to one of 1062 levels; mute or soft mute is the last
   function [10:0] avc_lvl;
      input [7:0] code;
      input mute;
      reg [13:0] part;
      begin
         part = {6'h00, code} * 14'd41;
         if (mute | code == `AVC_VOL_MUTE_CODE) begin
            avc_lvl = `AVC_RAMP_MUTE;
         end else begin
            avc_lvl = {1'b0, code, 2'b00} + {5'h00, part[13:8]};
         end
      end
   endfunction

   avc_ramp u_ramp_left (
      .clock(clock),
      .rst_n(rst_sync_r),
      .tick(tick_r),
      .fast(ramp_time_sel),
      .target(tgt_left),
      .level_r(left_vol_level)
   );

   avc_ramp u_ramp_right (
      .clock(clock),
      .rst_n(rst_sync_r),
      .tick(tick_r),
      .fast(ramp_time_sel),
      .target(tgt_right),
      .level_r(right_vol_level)
   );
endmodule
`default_nettype wire

/* sim/avc_chain_props.sv */
// concurrent checks on the gain chain ports
`timescale 1ns/100ps
`default_nettype none
module avc_chain_props #(
   parameter FS_DIV = 568 // clocks per sample
) (
   input wire clock, // clock
   input wire reset_n, // reset
   input wire level_ctl_en, // level on
   input wire converter_power, // power
   input wire zero_cross_disable, // no wait
   input wire [1:0] deemph_sel, // mode in
   input wire ramp_time_sel, // fast ramp
   input wire hp_differential_sel, // type
   input wire hp_pseudo_sel, // type
   input wire [7:0] left_level_gain_r, // gain
   input wire [7:0] right_level_gain_r, // gain
   input wire [1:0] deemph_mode_r, // mode
   input wire [1:0] hp_out_type_r, // type
   input wire [10:0] left_vol_level, // level
   input wire fs_tick // sample pulse
);
   logic [3:0] live_r = 4'h0;
   wire run = level_ctl_en & converter_power;
   wire [1:0] hp_sel = {hp_differential_sel, hp_pseudo_sel};
   // covers the two-flop reset release
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         live_r <= 4'h0;
      else
         live_r <= {live_r[2:0], 1'b1};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!live_r[3]);
   sequence ctl_start_s;
      $rose(run);
   endsequence
   deemph_follow_a: assert property (1'b1 |=> deemph_mode_r == $past(deemph_sel))
      else $error("deemph mode wrong");
   type_follow_a: assert property (1'b1 |=> hp_out_type_r ==
      ($past(hp_sel) == 2'h3 ? $past(hp_out_type_r) : $past(hp_sel))) else $error("type wrong");
   start_common_a: assert property (ctl_start_s |=> left_level_gain_r == right_level_gain_r)
      else $error("start gains differ");
   run_hold_a: assert property (run && $past(run) && $past(run, 2) |->
      $stable(left_level_gain_r) && $stable(right_level_gain_r)) else $error("gain moved");
   gain_moment_a: assert property (!$stable(left_level_gain_r) |->
      $past(fs_tick) || $past(zero_cross_disable) || $past(run)) else $error("gain off tick");
   vol_moment_a: assert property (!$stable(left_vol_level) |-> $past(fs_tick))
      else $error("level off tick");
   slow_step_a: assert property ($past(fs_tick) && !$past(ramp_time_sel) |->
      left_vol_level == $past(left_vol_level) || left_vol_level == $past(left_vol_level) + 11'h001
      || left_vol_level + 11'h001 == $past(left_vol_level)) else $error("slow step wrong");
   vol_cap_a: assert property (left_vol_level <= 11'h425)
      else $error("level past mute");
endmodule
bind avc_chain avc_chain_props #(.FS_DIV(FS_DIV)) props (
   .clock(clock),
   .reset_n(reset_n),
   .level_ctl_en(level_ctl_en),
   .converter_power(converter_power),
   .zero_cross_disable(zero_cross_disable),
   .deemph_sel(deemph_sel),
   .ramp_time_sel(ramp_time_sel),
   .hp_differential_sel(hp_differential_sel),
   .hp_pseudo_sel(hp_pseudo_sel),
   .left_level_gain_r(left_level_gain_r),
   .right_level_gain_r(right_level_gain_r),
   .deemph_mode_r(deemph_mode_r),
   .hp_out_type_r(hp_out_type_r),
   .left_vol_level(left_vol_level),
   .fs_tick(fs_tick)
);
`default_nettype wire

/* sim/audio_volume_mute_chain_test.sv */
// self-checking bench for the gain chain
`timescale 1ns/100ps
`default_nettype none
module audio_volume_mute_chain_test;
   logic clock = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic level_ctl_en = 1'b0, converter_power = 1'b0, zero_cross_disable = 1'b1;
   logic volume_link = 1'b0, ramp_time_sel = 1'b0, soft_silence = 1'b0;
   logic hp_differential_sel = 1'b0, hp_pseudo_sel = 1'b0;
   logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00, d;
   logic [7:0] left_out_volume = 8'h00, right_out_volume = 8'h00;
   logic [1:0] zc_timeout_sel = 2'h0, deemph_sel = 2'h1;
   logic [23:0] sample_left = 24'h000100, sample_right = 24'h000100;
   wire [7:0] rd_data, left_level_gain_r, right_level_gain_r;
   wire [1:0] deemph_mode_r, hp_out_type_r;
   wire [10:0] left_vol_level, right_vol_level;
   wire fs_tick;
   int fails = 0, tests_run = 0, lim;
   // {deemph in, type bits in, type expected}
   logic [5:0] rows [4] = '{6'b001010, 6'b010101, 6'b101101, 6'b110000};
   avc_chain #(.FS_DIV(4)) DUT (
      .clock(clock),
      .reset_n(reset_n),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .level_ctl_en(level_ctl_en),
      .converter_power(converter_power),
      .zero_cross_disable(zero_cross_disable),
      .zc_timeout_sel(zc_timeout_sel),
      .deemph_sel(deemph_sel),
      .left_out_volume(left_out_volume),
      .right_out_volume(right_out_volume),
      .volume_link(volume_link),
      .ramp_time_sel(ramp_time_sel),
      .soft_silence(soft_silence),
      .hp_differential_sel(hp_differential_sel),
      .hp_pseudo_sel(hp_pseudo_sel),
      .sample_left(sample_left),
      .sample_right(sample_right),
      .left_level_gain_r(left_level_gain_r),
      .right_level_gain_r(right_level_gain_r),
      .deemph_mode_r(deemph_mode_r),
      .hp_out_type_r(hp_out_type_r),
      .left_vol_level(left_vol_level),
      .right_vol_level(right_vol_level),
      .fs_tick(fs_tick)
   );
   always #20 clock = ~clock;
   task automatic chk(input string what, input logic [10:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * 4) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge clock);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= v;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      // read data stands from the edge after the strobe
      @(posedge clock);
      d = rd_data;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      chk("gain", left_level_gain_r, 8'hf1);
      chk("deemph", deemph_mode_r, 2'h1);
      chk("type", hp_out_type_r, 2'h0);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         deemph_sel <= rows[i][5:4];
         {hp_differential_sel, hp_pseudo_sel} <= rows[i][3:2];
         repeat (3) @(posedge clock);
         chk("deemph", deemph_mode_r, rows[i][5:4]);
         chk("type", hp_out_type_r, rows[i][1:0]);
      end
      wr(8'h09, 8'h91);
      wr(8'h0c, 8'h91);
      repeat (2) @(posedge clock);
      chk("left", left_level_gain_r, 8'h91);
      chk("right", right_level_gain_r, 8'h91);
      rd(8'h09);
      chk("read", d, 8'h91);
      rd(8'h55);
      chk("unmapped", d, 8'h00);
      zero_cross_disable <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         zc_timeout_sel <= s[1:0];
         lim = 128 << s;
         wr(8'h0c, 8'h20 + s[7:0]);
         wr(8'h09, 8'h30 + s[7:0]);
         ticks(lim / 2);
         wr(8'h0c, 8'h20 + s[7:0]);
         wr(8'h09, 8'h40 + s[7:0]);
         ticks(lim / 2 - 4);
         chk("early", right_level_gain_r, s == 0 ? 8'h91 : 8'h1f + s[7:0]);
         ticks(8);
         chk("timeout", right_level_gain_r, 8'h20 + s[7:0]);
         chk("restart", left_level_gain_r, 8'h91);
      end
      sample_left <= 24'hfff000;
      ticks(3);
      chk("crossing", left_level_gain_r, 8'h43);
      level_ctl_en <= 1'b1;
      converter_power <= 1'b1;
      ticks(1);
      chk("start", right_level_gain_r, 8'h43);
      wr(8'h0c, 8'h77);
      rd(8'h0c);
      chk("ignored", d, 8'h23);
      level_ctl_en <= 1'b0;
      zc_timeout_sel <= 2'h0;
      ticks(136);
      chk("resume", right_level_gain_r, 8'h23);
      level_ctl_en <= 1'b1;
      ticks(1);
      chk("again", right_level_gain_r, 8'h43);
      level_ctl_en <= 1'b0;
      right_out_volume <= 8'hff;
      ticks(1070);
      chk("mute code", right_vol_level, 11'h425);
      chk("released", right_level_gain_r, 8'h23);
      chk("apart", left_vol_level, 11'h000);
      volume_link <= 1'b1;
      ramp_time_sel <= 1'b1;
      ticks(262);
      chk("linked", right_vol_level, 11'h000);
      soft_silence <= 1'b1;
      ticks(262);
      chk("silence", left_vol_level, 11'h425);
      soft_silence <= 1'b0;
      ticks(262);
      chk("back", left_vol_level, 11'h000);
      soft_silence <= 1'b1;
      ticks(60);
      soft_silence <= 1'b0;
      left_out_volume <= 8'h18;
      ticks(80);
      chk("cancel", left_vol_level, 11'h063);
      // reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("reset gain", right_level_gain_r, 8'hf1);
      chk("reset deemph", deemph_mode_r, 2'h1);
      chk("reset level", left_vol_level, 11'h000);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      rd(8'h0c);
      chk("reset read", d, 8'hf1);
      lim = 0;
      repeat (8) begin
         @(posedge clock);
         lim += fs_tick;
      end
      chk("tick rate", lim, 2);
      final_report;
   end
endmodule
`default_nettype wire
